// File: hw/acmpc_pkg.sv
// Package for the comparator control logic: offsets, fields, resets, timing
package acmpc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [2:0] OFS_MAIN_CONTROL = 3'h0;
  localparam logic [2:0] OFS_INPUT_SELECT = 3'h2;
  localparam logic [2:0] OFS_IRQ_ENABLE   = 3'h6;
  localparam logic [2:0] OFS_FLAG_LEVEL   = 3'h7;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_ENABLE     = 0;
  localparam int BIT_HYS_LO     = 1;
  localparam int BIT_LOW_CUR    = 3;
  localparam int BIT_EDGE_LO    = 4;
  localparam int BIT_PIN_OUT_EN = 6;
  localparam int BIT_RUN_STDBY  = 7;
  localparam int BIT_NEG_LO     = 0;
  localparam int BIT_POS_LO     = 3;
  localparam int BIT_INVERT     = 7;
  localparam int BIT_IRQ_EN     = 0;
  localparam int BIT_FLAG       = 0;
  localparam int BIT_LEVEL      = 4;

  // ****************************************************************
  // Reset values and write masks
  // ****************************************************************
  localparam logic [7:0] RST_MAIN_CONTROL = 8'h00;
  localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE   = 8'h00;
  localparam logic [7:0] MSK_INPUT_SELECT = 8'h9B;
  localparam logic [7:0] MSK_IRQ_ENABLE   = 8'h01;

  // Edge mode encodings
  localparam logic [1:0] EDGE_ANY     = 2'h0;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_RISING  = 2'h3;

  // Interrupt vector relative offset
  localparam logic [7:0] COMPARATOR_VECTOR = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int  CLK_PERIOD_PS     = 8000;
  localparam int  STARTUP_TIME_PS   = 2500000;
  localparam int  STARTUP_CYCLES    = (STARTUP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int  REF_SETTLE_US     = 60;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ACMPC_ACTIVE,
    ACMPC_IDLE,
    ACMPC_STANDBY,
    ACMPC_POWER_DOWN
  } acmpc_sleep_e;

  // Settings handed to the analog core
  typedef struct packed {
    logic       enable;
    logic       low_current_select;
    logic [1:0] hysteresis_select;
    logic [1:0] positive_input_select;
    logic [1:0] negative_input_select;
  } acmpc_analog_s;

endpackage : acmpc_pkg

// File: hw/acmpc_top.sv
// Comparator control logic: registers, sleep gating, edge flag, pin and event out
`timescale 1ns/1ns
// What this block does
// - Output marked invalid during 2.5 us start-up
// - Two-bit hysteresis select: off or three levels
// - Main control bit 3 selects low current
// - Enabled comparator drives unsynchronised event output
// - No event input; generator only
// - Matching edge sets status flag, vector 0x00
// - Request while flag and enable both set
// - Edge mode bits 5:4 choose edges
// - Bit 6 drives result onto pin
// - Bit 7 keeps comparator running in standby
// - Standby without clock: no status, events continue if bit 7 set
// - Idle sleep behaves as active
// - Power-down disables comparator and pin
// - Debug halt changes nothing
// - Registers at 0x00, 0x02, 0x06, 0x07
// - Registers and flags run on peripheral clock
// - Writing one clears the status flag
// - Status bit 4 shows level after three cycles
// - Invert bit flips output for all consumers
// - Interrupt enable bit 0 enables the source
module acmpc_top (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  // Register port
  input  wire logic [2:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  // System sleep state and peripheral clock request from other modules
  input  wire acmpc_pkg::acmpc_sleep_e sleep_mode,
  input  wire logic                    per_clk_requested,
  // Analog core
  output acmpc_pkg::acmpc_analog_s     analog_cfg,
  input  wire logic                    comparator_raw,
  // Outputs
  output logic                         comparator_event,
  output logic                         pin_out,
  output logic                         pin_out_oe,
  output logic                         output_valid,
  output logic                         irq_req,
  output logic      [7:0]              irq_vector
);
  import acmpc_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0]  main_control_q;
  logic [7:0]  input_select_q;
  logic [7:0]  irq_enable_q;
  logic        flag_q;
  logic [2:0]  sync_q;
  logic        prev_q;
  logic        prev_valid_q;
  logic [15:0] startup_cnt_q;
  logic [15:0] startup_cnt_d;

  // ****************************************************************
  // Decode and field extraction
  // ****************************************************************
  wire sel_main  = (reg_addr == OFS_MAIN_CONTROL);
  wire sel_input = (reg_addr == OFS_INPUT_SELECT);
  wire sel_irqen = (reg_addr == OFS_IRQ_ENABLE);
  wire sel_flag  = (reg_addr == OFS_FLAG_LEVEL);

  wire       enable_bit         = main_control_q[BIT_ENABLE];
  wire       keep_running_in_standby = main_control_q[BIT_RUN_STDBY];
  wire       pin_output_enable  = main_control_q[BIT_PIN_OUT_EN];
  wire [1:0] edge_mode          = main_control_q[BIT_EDGE_LO +: 2];
  wire       invert_bit         = input_select_q[BIT_INVERT];
  wire       compare_irq_bit    = irq_enable_q[BIT_IRQ_EN];

  // Sleep gating; debug halt is no input here, so it cannot alter anything
  wire power_down   = (sleep_mode == ACMPC_POWER_DOWN);
  wire in_standby   = (sleep_mode == ACMPC_STANDBY);
  // Idle is treated exactly like active
  wire core_running = enable_bit && !power_down &&
                      (!in_standby || keep_running_in_standby);
  // Status logic is frozen in standby when the peripheral clock is not requested
  wire status_live  = !in_standby || per_clk_requested;

  // ****************************************************************
  // Analog core settings
  // ****************************************************************
  assign analog_cfg.enable                = core_running;
  assign analog_cfg.low_current_select    = main_control_q[BIT_LOW_CUR];
  assign analog_cfg.hysteresis_select     = main_control_q[BIT_HYS_LO +: 2];
  assign analog_cfg.positive_input_select = input_select_q[BIT_POS_LO +: 2];
  assign analog_cfg.negative_input_select = input_select_q[BIT_NEG_LO +: 2];

  // Event and pin paths stay combinational: the event is asynchronous by
  // nature, so registering it would add latency the consumers do not expect
  wire cmp_out = (comparator_raw ^ invert_bit) & core_running;
  assign comparator_event = cmp_out;
  assign pin_out          = cmp_out;
  assign pin_out_oe       = pin_output_enable && !power_down;

  // ****************************************************************
  // Start-up blanking counter
  // ****************************************************************
  always_comb begin
    startup_cnt_d = startup_cnt_q;
    if (!core_running) begin
      startup_cnt_d = 16'h0000;
    end else if (startup_cnt_q < 16'(STARTUP_CYCLES)) begin
      startup_cnt_d = startup_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      startup_cnt_q <= 16'h0000;
    end else begin
      startup_cnt_q <= startup_cnt_d;
    end
  end

  // Reference settling is not tracked here; software waits for it
  assign output_valid = core_running && (startup_cnt_q >= 16'(STARTUP_CYCLES));

  // ****************************************************************
  // Synchroniser and edge detection
  // ****************************************************************
  // Three stages feed edge detection; the status level taps stage two plus a register for the three-cycle delay
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], cmp_out};
    end
  end

  wire level_now = sync_q[2];
  // Ignore edges until output_valid; the three-stage lag still lets the last three start-up samples be compared
  wire sample_ok = status_live && output_valid;
  wire rise      = prev_valid_q && level_now && !prev_q;
  wire fall      = prev_valid_q && !level_now && prev_q;
  wire edge_hit  = sample_ok && (
                     ((edge_mode == EDGE_ANY)     && (rise || fall)) ||
                     ((edge_mode == EDGE_FALLING) && fall) ||
                     ((edge_mode == EDGE_RISING)  && rise));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_q       <= 1'b0;
      prev_valid_q <= 1'b0;
    end else if (status_live) begin
      prev_q       <= level_now;
      prev_valid_q <= output_valid;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  wire flag_clear = reg_wr && sel_flag && reg_wdata[BIT_FLAG];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      main_control_q <= RST_MAIN_CONTROL;
      input_select_q <= RST_INPUT_SELECT;
      irq_enable_q   <= RST_IRQ_ENABLE;
    end else if (reg_wr) begin
      if (sel_main)  main_control_q <= reg_wdata;
      if (sel_input) input_select_q <= reg_wdata & MSK_INPUT_SELECT;
      if (sel_irqen) irq_enable_q   <= reg_wdata & MSK_IRQ_ENABLE;
    end
  end

  // Set wins over a clear in the same cycle so no edge is lost
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= 1'b0;
    end else if (edge_hit) begin
      flag_q <= 1'b1;
    end else if (flag_clear) begin
      flag_q <= 1'b0;
    end
  end

  // Request held as long as flag and enable stand together
  assign irq_req    = flag_q && compare_irq_bit;
  assign irq_vector = COMPARATOR_VECTOR;

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Status level bit freezes with the clock in standby
  logic level_shown_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      level_shown_q <= 1'b0;
    end else if (status_live) begin
      level_shown_q <= sync_q[1];
    end
  end

  wire [7:0] status_view = (8'(level_shown_q) << BIT_LEVEL) | (8'(flag_q) << BIT_FLAG);
  wire [7:0] rd_mux = sel_main  ? main_control_q :
                      sel_input ? input_select_q :
                      sel_irqen ? irq_enable_q   :
                      sel_flag  ? status_view    : 8'h00;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule : acmpc_top

// File: tb/acmpc_top_asserts.sv
// Port assertions for the comparator control block
`timescale 1ns/1ns
module acmpc_top_asserts (
  // Watched ports of the block
  input wire logic clk_sys, arst_n, reg_wr, reg_rd, per_clk_requested,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata, irq_vector,
  input wire acmpc_pkg::acmpc_sleep_e sleep_mode,
  input wire acmpc_pkg::acmpc_analog_s analog_cfg,
  input wire logic comparator_event, pin_out, pin_out_oe, output_valid, irq_req
);
  import acmpc_pkg::*;
  // ****
  // Checks in the peripheral clock domain
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_vector_const: assert property (irq_vector == COMPARATOR_VECTOR)
    else $error("vector offset not zero");
  a_pin_follows: assert property (pin_out == comparator_event)
    else $error("pin differs from event");
  a_powerdown_off: assert property (sleep_mode == ACMPC_POWER_DOWN |-> !pin_out_oe)
    else $error("pin enabled in power-down");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_hole_zero: assert property ($past(reg_rd) && $past(reg_addr) inside {1, 3, 4, 5}
    |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_startup_hold: assert property ($rose(analog_cfg.enable) |-> !output_valid [*8])
    else $error("valid too soon after enable");
  a_cfg_update: assert property (reg_wr && reg_addr == OFS_MAIN_CONTROL |=>
    analog_cfg[7:4] == {$past(reg_wdata[0]), $past(reg_wdata[3:1])}) else $error("settings lost");
  a_standby_quiet: assert property ($past(sleep_mode) == ACMPC_STANDBY
    && !$past(per_clk_requested) && !$past(reg_wr) |-> !$rose(irq_req))
    else $error("request raised in standby");
  a_oe_follows: assert property (reg_wr && reg_addr == OFS_MAIN_CONTROL |=>
    pin_out_oe == ($past(reg_wdata[BIT_PIN_OUT_EN]) && sleep_mode != ACMPC_POWER_DOWN))
    else $error("pin enable does not follow control");
  c_irq: cover property ($rose(irq_req));
  c_standby: cover property (sleep_mode == ACMPC_STANDBY && comparator_event);
  c_level: cover property ($past(reg_rd) && reg_rdata[BIT_LEVEL]);
endmodule : acmpc_top_asserts
bind acmpc_top acmpc_top_asserts u_chk (.*);

// File: tb/acmpc_partner.sv
// Behavioural analog comparator core for the bench
`timescale 1ns/1ns
module acmpc_partner (
  // Settings and clock in, comparator result out
  input wire acmpc_pkg::acmpc_analog_s analog_cfg,
  input wire logic level, clk_sys,
  output logic comparator_raw
);
  import acmpc_pkg::*;
  logic chatter_q = 1'b0;
  int settle_q = 0;
  // Output is junk until the core has settled, so the block must ignore it
  always @(posedge clk_sys) begin
    chatter_q <= ~chatter_q;
    settle_q <= analog_cfg.enable ? settle_q + 1 : 0;
  end
  // Settling stands for core and reference start-up alike
  assign comparator_raw = (settle_q > 300) ? level : chatter_q;
endmodule : acmpc_partner

// File: tb/test_acmpc_top.sv
// Self-checking testbench for the comparator control block
`timescale 1ns/1ns
module test_acmpc_top;
  import acmpc_pkg::*;
  // ****
  // Stimulus, clock, instances and shared tasks
  // ****
  logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, level = 1'b0;
  logic per_clk_requested = 1'b0, comparator_raw, comparator_event, pin_out, pin_out_oe;
  logic output_valid, irq_req;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, irq_vector;
  acmpc_sleep_e sleep_mode = ACMPC_ACTIVE;
  acmpc_analog_s analog_cfg;
  int miscompares = 0, comparisons = 0;
  initial forever #4 clk_sys = ~clk_sys;
  acmpc_top u_dut (
    .clk_sys           (clk_sys),
    .arst_n            (arst_n),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .sleep_mode        (sleep_mode),
    .per_clk_requested (per_clk_requested),
    .analog_cfg        (analog_cfg),
    .comparator_raw    (comparator_raw),
    .comparator_event  (comparator_event),
    .pin_out           (pin_out),
    .pin_out_oe        (pin_out_oe),
    .output_valid      (output_valid),
    .irq_req           (irq_req),
    .irq_vector        (irq_vector)
  );
  acmpc_partner u_core (
    .analog_cfg     (analog_cfg),
    .level          (level),
    .clk_sys        (clk_sys),
    .comparator_raw (comparator_raw)
  );
  task automatic check(input string s, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    if (seen !== exp) miscompares++;
  endtask : check
  task automatic give_verdict;
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // One register cycle; a read compares the data of the following cycle
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d, input string s = "");
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 if (!w) check(s, reg_rdata, d);
  endtask : bus
  // Set sleep state and wanted level, then let n cycles pass
  task automatic step(input acmpc_sleep_e m, input logic v, input int n);
    @(posedge clk_sys);
    sleep_mode <= m;
    level <= v;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  // Reset values, write masks and unmapped holes
  task automatic t_regs;
    for (int a = 0; a < 8; a++) bus(0, a[2:0], 8'h00, "reset value");
    for (int a = 0; a < 7; a++) bus(1, a[2:0], a ? 8'hFF : 8'hFE);
    for (int a = 0; a < 7; a++)
      bus(0, a[2:0], a == 2 ? 8'h9B : a == 6 ? 8'h01 : a ? 8'h00 : 8'hFE, "mask");
    check("settings", analog_cfg, 8'h7F);
    check("vector", irq_vector, COMPARATOR_VECTOR);
  endtask : t_regs
  // Inputs chosen before enabling; result held back during start-up
  task automatic t_start;
    bus(1, OFS_INPUT_SELECT, 8'h00);
    bus(1, OFS_IRQ_ENABLE, 8'h01);
    bus(1, OFS_MAIN_CONTROL, 8'h41);
    step(ACMPC_ACTIVE, 1'b0, 300);
    check("early valid", output_valid, 8'h00);
    step(ACMPC_ACTIVE, 1'b0, 20);
    check("late valid", {output_valid, pin_out_oe}, 8'h03);
    bus(1, OFS_INPUT_SELECT, 8'h80);
    check("inverted", {comparator_event, pin_out}, 8'h03);
    step(ACMPC_ACTIVE, 1'b0, 8);
    bus(0, OFS_FLAG_LEVEL, 8'h11, "inverted status");
    bus(1, OFS_IRQ_ENABLE, 8'h00);
    check("irq off", irq_req, 8'h00);
    bus(1, OFS_IRQ_ENABLE, 8'h01);
    check("irq on", irq_req, 8'h01);
    bus(1, OFS_INPUT_SELECT, 8'h00);
    step(ACMPC_ACTIVE, 1'b0, 8);
    bus(1, OFS_FLAG_LEVEL, 8'h01);
  endtask : t_start
  // One rising and one falling edge under edge mode m
  task automatic t_edge(input logic [1:0] m);
    bus(1, OFS_MAIN_CONTROL, {2'b01, m, 4'h1});
    step(ACMPC_ACTIVE, 1'b1, 8);
    check("irq rise", irq_req, {7'h00, m == EDGE_ANY || m == EDGE_RISING});
    bus(0, OFS_FLAG_LEVEL, {7'h08, m == EDGE_ANY || m == EDGE_RISING}, "rise");
    bus(1, OFS_FLAG_LEVEL, 8'h01);
    step(ACMPC_ACTIVE, 1'b0, 8);
    check("irq fall", irq_req, {7'h00, m == EDGE_ANY || m == EDGE_FALLING});
    bus(0, OFS_FLAG_LEVEL, {7'h00, m == EDGE_ANY || m == EDGE_FALLING}, "fall");
    bus(1, OFS_FLAG_LEVEL, 8'h01);
  endtask : t_edge
  // Idle acts as active, standby runs without flagging, power-down stops all
  task automatic t_sleep;
    bus(1, OFS_MAIN_CONTROL, 8'hC1);
    step(ACMPC_IDLE, 1'b1, 8);
    bus(0, OFS_FLAG_LEVEL, 8'h11, "idle");
    bus(1, OFS_FLAG_LEVEL, 8'h01);
    step(ACMPC_STANDBY, 1'b0, 8);
    check("standby low", {comparator_event, irq_req}, 8'h00);
    step(ACMPC_STANDBY, 1'b1, 8);
    check("standby high", {comparator_event, irq_req}, 8'h02);
    step(ACMPC_ACTIVE, 1'b1, 8);
    bus(0, OFS_FLAG_LEVEL, 8'h10, "after standby");
    bus(1, OFS_MAIN_CONTROL, 8'h41);
    step(ACMPC_STANDBY, 1'b1, 2);
    check("halted", comparator_event, 8'h00);
    step(ACMPC_POWER_DOWN, 1'b1, 2);
    check("power-down", {comparator_event, pin_out_oe}, 8'h00);
  endtask : t_sleep
  // Reset for 12 cycles, scenarios in turn, then the verdict
  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs;
    t_start;
    for (int m = 0; m < 4; m++) t_edge(m[1:0]);
    t_sleep;
    give_verdict;
  end
  // Watchdog: the scenarios need about 600 cycles, far below this span
  initial begin
    #100000;
    miscompares++;
    give_verdict;
  end
endmodule : test_acmpc_top
